// *** irpl_chan.sv ***
/*
 * One request channel: edge or level recognition of a synchronised
 * request; a latched edge is held pending until the core clears it.
 * Assumes level_in is already synchronous to clk.
 */
module irpl_chan (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level_in,
	input wire logic level_mode,
	input wire logic enable,
	input wire logic clear,
	output logic pending
);

	logic prev;
	logic rise;
	logic next_pending;

	// edge: latch the rising transition, a set beats a clear in one cycle
	// level: follow the line, so a dropped request is simply gone
	assign rise = level_in & ~prev;
	assign next_pending = !enable ? 1'b0 :
		level_mode ? level_in :
		(rise | (pending & ~clear));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
			pending <= 1'b0;
		end else begin
			prev <= level_in;
			pending <= next_pending;
		end
	end

endmodule

// *** irpl_periph.sv ***
/*
 * Peripheral model for the request pins: one nmi pulse source and four
 * maskable requesters.
 * Assumes raise pulses come from the bench and ack_done from the core side.
 */
module irpl_periph (
	input wire logic clk,
	input wire logic [4:0] raise,
	input wire logic ack_done,
	input wire logic [1:0] ack_index,
	output logic nmi_pin,
	output logic [3:0] req
);
	// ==========================================================
	// requesters
	initial begin
		nmi_pin = 1'b0;
		req = 4'h0;
	end
	// nmi held for exactly one clock, the shortest legal pulse
	always @(posedge clk) begin
		nmi_pin <= raise[4];
		for (int i = 0; i < 4; i++) begin
			if (raise[i])
				req[i] <= 1'b1;
			else if (ack_done && ack_index == i[1:0])
				req[i] <= 1'b0; // held until acknowledged
		end
	end
endmodule

// *** irpl_pkg.sv ***
/*
 * Shared constants for the interrupt request pin front end: register
 * offsets, control field positions, reset values, pin indices and the
 * interrupt type taken for a non-maskable request.
 * Assumes a plain register port with byte addresses on an 8-bit address.
 */
package irpl_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_REQ = 4;
	localparam int NUM_PINS = 5;
	localparam int NUM_EVT = 5;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h08;
	localparam logic [ADDR_W-1:0] PEND_ADDR = 8'h0c;

	// ==========================================================
	// control fields: bits 3:0 choose level (1) or edge (0) per request
	localparam int CTRL_LEVEL_LSB = 0;
	localparam int CTRL_ACK0_BIT = 4;
	localparam int CTRL_ACK1_BIT = 5;
	localparam int CTRL_SUB_BIT = 6;
	localparam int CTRL_W = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam logic [NUM_EVT-1:0] MASK_RESET = 5'h00;

	// ==========================================================
	// status event bits: 0..3 maskable request latched, 4 nmi taken
	localparam int EVT_NMI_BIT = 4;

	// ==========================================================
	// synchronised pin vector and pending view positions
	localparam int PIN_NMI = 4;
	localparam int PEND_NMI_BIT = 4;
	localparam int PEND_SEL_BIT = 5;
	localparam int PEND_W = 6;

	// ==========================================================
	// core side
	localparam int VEC_W = 8;
	localparam logic [VEC_W-1:0] NMI_TYPE = 8'h02;
	localparam logic [1:0] ACK_IDX_0 = 2'h0;
	localparam logic [1:0] ACK_IDX_1 = 2'h1;

endpackage

// *** irpl_sync.sv ***
/*
 * Two-stage (or deeper) synchroniser for a group of level inputs.
 * Assumes the inputs are asynchronous to clk; only the last stage is read.
 */
module irpl_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	// ==========================================================
	// parameter check
	if (STAGES < 2) begin : g_bad_stages
		$error("irpl_sync needs at least two stages");
	end

	logic [WIDTH-1:0] stage [STAGES];

	// shift chain; the first stage feeds only the next stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STAGES; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign q = stage[STAGES-1];

endmodule

// *** irpl_top.sv ***
/*
 * Interrupt request pin front end: the non-maskable request pin and four
 * maskable request pins, two of which can serve as active-low acknowledge
 * outputs, plus a small register file with sticky event status.
 * Assumes the core pulses instr_boundary between instructions, holds
 * ack_cycle with ack_index during an acknowledge cycle, and pulses
 * ack_done with ack_index when a maskable request has been taken.
 */
// Behaviour
// - an accepted non-maskable request takes interrupt type 2
// - the nmi pin is synchronised, then its rising edge is latched before use
// - a synchronised nmi is serviced at the next instruction boundary
// - nothing programmable masks or disables the non-maskable request
// - maskable request inputs are active high and synchronised to the clock
// - request pins two and three can act as active-low acknowledge outputs
// - each maskable input is configurable as edge or level triggered
// - subordinate mode reassigns the maskable request pin functions
module irpl_top
	import irpl_pkg::*;
#(
	parameter int NUM_REQ_P = irpl_pkg::NUM_REQ
) (
	input wire logic clk,
	input wire logic reset_n,
	// pins
	input wire logic nmi_pin,
	input wire logic request_line_0,
	input wire logic request_line_1_or_select,
	input wire logic request_line_2_or_ack_0_in,
	output logic request_line_2_or_ack_0_out,
	output logic request_line_2_or_ack_0_oe_n,
	input wire logic request_line_3_or_ack_1_in,
	output logic request_line_3_or_ack_1_out,
	output logic request_line_3_or_ack_1_oe_n,
	// core side
	input wire logic instr_boundary,
	input wire logic ack_cycle,
	input wire logic ack_done,
	input wire logic [1:0] ack_index,
	output logic nmi_take,
	output logic [irpl_pkg::VEC_W-1:0] nmi_vector,
	output logic [irpl_pkg::NUM_REQ-1:0] int_request,
	output logic select_level,
	// register port
	input wire logic [irpl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [irpl_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [irpl_pkg::DATA_W-1:0] reg_rdata,
	output logic irq
);
	import irpl_pkg::*;

	// ==========================================================
	// parameter check
	if (NUM_REQ_P != NUM_REQ) begin : g_bad_req
		$error("irpl_top serves exactly four maskable requests");
	end

	// ==========================================================
	// reset release through two flip-flops
	logic rst_n;

	irpl_sync #(.WIDTH(1), .STAGES(2)) u_rst_sync (
		.clk(clk),
		.rst_n(reset_n),
		.d(1'b1),
		.q(rst_n)
	);

	// ==========================================================
	// pin synchronisers; every pin is sampled on each clock, so a
	// request held one clock period is seen
	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_sync;

	assign pin_raw = {nmi_pin, request_line_3_or_ack_1_in,
		request_line_2_or_ack_0_in, request_line_1_or_select, request_line_0};

	irpl_sync #(.WIDTH(NUM_PINS), .STAGES(2)) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(pin_raw),
		.q(pin_sync)
	);

	// ==========================================================
	// registers
	logic [CTRL_W-1:0] ctrl;
	logic [NUM_EVT-1:0] status;
	logic [NUM_EVT-1:0] mask;

	// control field decode
	wire [NUM_REQ-1:0] level_mode = ctrl[CTRL_LEVEL_LSB +: NUM_REQ];
	wire ack0_mode = ctrl[CTRL_ACK0_BIT];
	wire ack1_mode = ctrl[CTRL_ACK1_BIT];
	wire sub_mode = ctrl[CTRL_SUB_BIT];

	// address decode
	wire hit_ctrl = reg_addr == CTRL_ADDR;
	wire hit_status = reg_addr == STATUS_ADDR;
	wire hit_mask = reg_addr == MASK_ADDR;
	wire hit_pend = reg_addr == PEND_ADDR;
	wire wr_ctrl = reg_write & hit_ctrl;
	wire wr_mask = reg_write & hit_mask;
	wire rd_status = reg_read & hit_status;

	// ==========================================================
	// request enables: a pin given over to acknowledge or to the
	// subordinate mode no longer raises requests
	logic [NUM_REQ-1:0] chan_en;

	assign chan_en[0] = 1'b1;
	assign chan_en[1] = ~sub_mode;
	assign chan_en[2] = ~sub_mode & ~ack0_mode;
	assign chan_en[3] = ~sub_mode & ~ack1_mode;

	// ==========================================================
	// maskable request channels, high level means asserted
	logic [NUM_REQ-1:0] req_clear;
	logic [NUM_REQ-1:0] req_pending;

	for (genvar i = 0; i < NUM_REQ; i++) begin : g_req
		assign req_clear[i] = ack_done & (ack_index == 2'(i));

		irpl_chan u_chan (
			.clk(clk),
			.rst_n(rst_n),
			.level_in(pin_sync[i]),
			.level_mode(level_mode[i]),
			.enable(chan_en[i]),
			.clear(req_clear[i]),
			.pending(req_pending[i])
		);
	end

	// pending requests go to the core straight from channel flops
	assign int_request = req_pending;

	// ==========================================================
	// non-maskable request: always edge, always enabled, no mask bit
	logic nmi_pending;
	logic nmi_accept;

	irpl_chan u_nmi_chan (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(pin_sync[PIN_NMI]),
		.level_mode(1'b0),
		.enable(1'b1),
		.clear(nmi_accept),
		.pending(nmi_pending)
	);

	// taken only between instructions, never mid-instruction
	assign nmi_accept = nmi_pending & instr_boundary;

	// take pulse and type go out from flops, one cycle after acceptance
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_take <= 1'b0;
			nmi_vector <= '0;
		end else begin
			nmi_take <= nmi_accept;
			nmi_vector <= nmi_accept ? NMI_TYPE : nmi_vector;
		end
	end

	// ==========================================================
	// pin outputs; oe_n low means this end drives the pin
	logic next_p2_out;
	logic next_p2_oe_n;
	logic next_p3_out;
	logic next_p3_oe_n;

	wire ack0_active = ack_cycle & (ack_index == ACK_IDX_0);
	wire ack1_active = ack_cycle & (ack_index == ACK_IDX_1);

	// acknowledge low only inside the cycle, high otherwise; in the
	// subordinate mode pin 3 becomes the request output to the main unit
	assign next_p2_out = ~(ack0_mode & ack0_active);
	assign next_p2_oe_n = ~ack0_mode | sub_mode;
	assign next_p3_out = sub_mode ? (|req_pending) : ~(ack1_mode & ack1_active);
	assign next_p3_oe_n = ~(ack1_mode | sub_mode);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			request_line_2_or_ack_0_out <= 1'b1;
			request_line_2_or_ack_0_oe_n <= 1'b1;
			request_line_3_or_ack_1_out <= 1'b1;
			request_line_3_or_ack_1_oe_n <= 1'b1;
			select_level <= 1'b0;
		end else begin
			request_line_2_or_ack_0_out <= next_p2_out;
			request_line_2_or_ack_0_oe_n <= next_p2_oe_n;
			request_line_3_or_ack_1_out <= next_p3_out;
			request_line_3_or_ack_1_oe_n <= next_p3_oe_n;
			select_level <= sub_mode & pin_sync[1];
		end
	end

	// ==========================================================
	// events and sticky status; a new event beats the read-clear
	logic [NUM_REQ-1:0] req_prev;
	logic [NUM_EVT-1:0] events;
	logic [NUM_EVT-1:0] next_status;

	assign events = {nmi_accept, req_pending & ~req_prev};
	assign next_status = (rd_status ? '0 : status) | events;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_prev <= '0;
			status <= '0;
		end else begin
			req_prev <= req_pending;
			status <= next_status;
		end
	end

	// single level interrupt while any unmasked status bit is set
	assign irq = |(status & mask);

	// ==========================================================
	// control and mask writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
			mask <= MASK_RESET;
		end else begin
			ctrl <= wr_ctrl ? reg_wdata[CTRL_W-1:0] : ctrl;
			mask <= wr_mask ? reg_wdata[NUM_EVT-1:0] : mask;
		end
	end

	// ==========================================================
	// read data, one cycle after the strobe; unmapped reads give zero
	logic [PEND_W-1:0] pend_view;
	logic [DATA_W-1:0] next_rdata;

	assign pend_view = {select_level, nmi_pending, req_pending};
	assign next_rdata = !reg_read ? '0 :
		hit_ctrl ? DATA_W'(ctrl) :
		hit_status ? DATA_W'(status) :
		hit_mask ? DATA_W'(mask) :
		hit_pend ? DATA_W'(pend_view) : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// assertions
	a_nmi_type_two: assert property (
		@(posedge clk) disable iff (!rst_n)
		nmi_take |-> nmi_vector == NMI_TYPE)
		else $error("nmi taken with wrong type");

	a_nmi_edge_latch: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(pin_sync[PIN_NMI]) |=> nmi_pending)
		else $error("nmi rising edge not latched");

	a_nmi_at_boundary: assert property (
		@(posedge clk) disable iff (!rst_n)
		nmi_take |-> $past(instr_boundary) && $past(nmi_pending))
		else $error("nmi taken off an instruction boundary");

	a_nmi_never_masked: assert property (
		@(posedge clk) disable iff (!rst_n)
		nmi_pending && instr_boundary |=>
		nmi_take ##1 (nmi_take == $past(nmi_pending && instr_boundary)))
		else $error("pending nmi not taken at boundary");

	a_level_request: assert property (
		@(posedge clk) disable iff (!rst_n)
		level_mode[0] && pin_sync[0] |=> int_request[0])
		else $error("level request not presented");

	a_edge_request: assert property (
		@(posedge clk) disable iff (!rst_n)
		!level_mode[0] && $rose(pin_sync[0]) |=> int_request[0])
		else $error("edge request not latched");

	a_ack_drive_low: assert property (
		@(posedge clk) disable iff (!rst_n)
		ack0_mode && !sub_mode && ack0_active |=>
		!request_line_2_or_ack_0_out && !request_line_2_or_ack_0_oe_n)
		else $error("acknowledge output not driven low");

	a_ack_idle_high: assert property (
		@(posedge clk) disable iff (!rst_n)
		ack1_mode && !sub_mode && !ack1_active |=> request_line_3_or_ack_1_out)
		else $error("acknowledge output low outside its cycle");

	a_ack_pin_ignored: assert property (
		@(posedge clk) disable iff (!rst_n)
		ack0_mode && $past(ack0_mode) |-> !req_pending[2])
		else $error("acknowledge pin raised a request");

	a_sub_reassign: assert property (
		@(posedge clk) disable iff (!rst_n)
		sub_mode |=> !request_line_3_or_ack_1_oe_n && !req_pending[1])
		else $error("subordinate mode left pins unchanged");

endmodule

// *** tb_interrupt_request_pin_logic.sv ***
/*
 * Self-checking bench for the request pin front end with a status model.
 * Assumes irpl_pkg, irpl_top and irpl_periph are compiled first.
 */
module tb_interrupt_request_pin_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import irpl_pkg::*;
	// ==========================================================
	// signals
	logic clk = 1'b0, reset_n = 1'b0, ib = 1'b0, ack_cycle = 1'b0, ack_done = 1'b0;
	logic reg_write = 1'b0, reg_read = 1'b0;
	logic [1:0] ack_index = 2'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, rdata, seed = 32'h38;
	logic [4:0] raise = 5'h00;
	wire logic nmi_pin, out2, oe2, out3, oe3, nmi_take, sel, irq;
	wire logic [3:0] req, ireq;
	wire logic [7:0] vec;
	wire logic [31:0] reg_rdata;
	// shared pins: the device wins while its enable is low
	wire logic p2 = oe2 ? req[2] : out2;
	wire logic p3 = oe3 ? req[3] : out3;
	wire logic [5:0] obs = {sel, nmi_take, ireq};
	int bad_count = 0, num_checks = 0, exp_status = 0, exp_mask = 0;

	initial begin
		forever #2 clk = ~clk;
	end

	irpl_periph irpl_periph_i (.clk(clk), .raise(raise), .ack_done(ack_done),
		.ack_index(ack_index), .nmi_pin(nmi_pin), .req(req));
	irpl_top irpl_top_i (.clk(clk), .reset_n(reset_n), .nmi_pin(nmi_pin),
		.request_line_0(req[0]), .request_line_1_or_select(req[1]),
		.request_line_2_or_ack_0_in(p2), .request_line_2_or_ack_0_out(out2),
		.request_line_2_or_ack_0_oe_n(oe2), .request_line_3_or_ack_1_in(p3),
		.request_line_3_or_ack_1_out(out3), .request_line_3_or_ack_1_oe_n(oe3),
		.instr_boundary(ib), .ack_cycle(ack_cycle), .ack_done(ack_done),
		.ack_index(ack_index), .nmi_take(nmi_take), .nmi_vector(vec),
		.int_request(ireq), .select_level(sel), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .irq(irq));

	// ==========================================================
	// tasks
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task complete_run;
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 rdata = reg_rdata;
	endtask
	// status read clears the model too, then irq must be low
	task rd_status;
		rd(STATUS_ADDR);
		chk(rdata, exp_status);
		exp_status = 0;
		chk({31'h0, irq}, 32'h0);
	endtask
	task rs(input logic [4:0] m);
		@(posedge clk);
		raise <= m;
		@(posedge clk);
		raise <= 5'h00;
	endtask
	task ack(input int i);
		@(posedge clk);
		ack_done <= 1'b1;
		ack_index <= i[1:0];
		@(posedge clk);
		ack_done <= 1'b0;
	endtask
	// bounded wait: a hang counts as a mismatch and the run goes on
	task wait_sig(input int b, input logic v);
		for (int n = 0; n < 12; n++) begin
			#1;
			if (obs[b] === v)
				return;
			@(posedge clk);
		end
		bad_count++;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		#1 chk({out2, oe2, out3, oe3, irq}, 32'h1e);
		rd(CTRL_ADDR);
		chk(rdata, {25'h0, CTRL_RESET});
		rd(MASK_ADDR);
		chk(rdata, {27'h0, MASK_RESET});
		rd(8'h10);
		chk(rdata, 32'h0);
		// nmi with every mask bit clear, no boundary yet
		rs(5'h10);
		for (int n = 0; n < 8; n++) begin
			@(posedge clk);
			#1 chk({31'h0, nmi_take}, 32'h0);
		end
		@(posedge clk);
		ib <= 1'b1;
		@(posedge clk);
		ib <= 1'b0;
		wait_sig(4, 1'b1);
		chk({24'h0, vec}, {24'h0, NMI_TYPE});
		exp_status = 32'h10;
		@(posedge clk);
		#1 chk({31'h0, nmi_take}, 32'h0);
		seed = xs(seed);
		wr(MASK_ADDR, seed | 32'h10);
		exp_mask = (seed | 32'h10) & 32'h1f;
		#1 chk({31'h0, irq}, 32'h1);
		rd(MASK_ADDR);
		chk(rdata, exp_mask);
		rd_status();
		// edge recognition on each request, released by acknowledge
		for (int i = 0; i < 4; i++) begin
			rs(5'h01 << i);
			wait_sig(i, 1'b1);
			exp_status |= 1 << i;
			ack(i);
			wait_sig(i, 1'b0);
		end
		rd_status();
		// level mode on request 0 survives the acknowledge strobe
		wr(CTRL_ADDR, 32'h1);
		rs(5'h01);
		wait_sig(0, 1'b1);
		exp_status = 1;
		ack(0);
		#1 chk({31'h0, ireq[0]}, 32'h1);
		wait_sig(0, 1'b0);
		rd_status();
		// pins 2 and 3 as acknowledge outputs
		wr(CTRL_ADDR, 32'h30);
		rs(5'h0c);
		repeat (6) @(posedge clk);
		#1 chk({ireq, out2, out3}, 32'h3);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			ack_cycle <= 1'b1;
			ack_index <= k[1:0];
			@(posedge clk);
			#1 chk(k ? {out3, oe3} : {out2, oe2}, 32'h0);
			@(posedge clk);
			ack_cycle <= 1'b0;
		end
		repeat (3) @(posedge clk);
		#1 chk({out2, out3}, 32'h3);
		ack(2);
		ack(3);
		// subordinate mode: pin 1 turns into a select input, pin 3
		// reports that request 0 is pending
		wr(CTRL_ADDR, 32'h40);
		rs(5'h03);
		repeat (6) @(posedge clk);
		#1 chk({ireq, sel}, 32'h3);
		chk({out3, oe3}, 32'h2);
		exp_status = 1;
		rd(PEND_ADDR);
		chk(rdata, 32'h21);
		ack(1);
		ack(0);
		wait_sig(5, 1'b0);
		wait_sig(0, 1'b0);
		rd_status();
		complete_run();
	end
endmodule
